/* File: pkg/sldc_if.sv */
// interface: register port between configuring host and deframer configuration
`timescale 1ns/1ns
interface sldc_if;
  logic wr_en; // one-cycle write strobe
  logic rd_en; // one-cycle read strobe
  logic [11:0] addr; // register byte address
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // read data, registered
  logic rvalid; // read answer pulse
  modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
  modport host (output wr_en, output rd_en, output addr, output wdata, input rdata,
    input rvalid);
endinterface : sldc_if

/* File: pkg/sldc_pkg.sv */
// package: register map, field positions and mode constants of the deframer configuration
package sldc_pkg;
  // register offsets (byte addresses on the serial register port)
  localparam logic [11:0] ADDR_CFG_ERR = 12'h030;
  localparam logic [11:0] ADDR_SYNC_PD = 12'h203;
  localparam logic [11:0] ADDR_LINK_CTRL = 12'h300;
  localparam logic [11:0] ADDR_LANE_SCR = 12'h453;
  localparam logic [11:0] ADDR_F_M1 = 12'h454;
  localparam logic [11:0] ADDR_K_M1 = 12'h455;
  localparam logic [11:0] ADDR_M_M1 = 12'h456;
  localparam logic [11:0] ADDR_RES = 12'h457;
  localparam logic [11:0] ADDR_PACK = 12'h458;
  localparam logic [11:0] ADDR_VER = 12'h459;
  localparam logic [11:0] ADDR_DENS = 12'h45a;
  localparam logic [11:0] ADDR_DESKEW = 12'h46c;
  localparam logic [11:0] ADDR_F = 12'h476;
  localparam logic [11:0] ADDR_LANE_EN = 12'h47d;
  // multiframe clock delay register, offset chosen here
  localparam logic [11:0] ADDR_MFC_DLY = 12'h4f0;
  // field positions
  localparam int DUAL_LINK_BIT = 3;
  localparam int LINK_PAGE_BIT = 2;
  localparam int SYNC1_PD_BIT = 0;
  localparam int SCRAMBLE_BIT = 7;
  localparam int HIGH_DENSITY_BIT = 7;
  localparam int ERR_MFC_DLY_BIT = 5;
  localparam int ERR_LMFS_BIT = 3;
  localparam int ERR_K_BIT = 2;
  localparam int ERR_SUBCLASS_BIT = 1;
  // field values
  localparam logic [4:0] K32_M1 = 5'h1f;
  localparam logic [4:0] K16_M1 = 5'h0f;
  localparam logic [7:0] M_ONE_M1 = 8'h00;
  localparam logic [4:0] RES16_M1 = 5'h0f;
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [2:0] VERSION_B = 3'h1;
  localparam logic [4:0] MFC_DLY_MAX = 5'h1f;
  // reset values: single link, mode 8 defaults
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LANE_SCR = 8'h03;
  localparam logic [7:0] RST_K = 8'h1f;
  localparam logic [7:0] RST_RES = 8'h0f;
  localparam logic [7:0] RST_PACK = 8'h0f;
  localparam logic [7:0] RST_VER = 8'h21;
  localparam logic [7:0] RST_DENS = 8'h80;
  localparam logic [7:0] RST_F = 8'h01;
  localparam logic [7:0] RST_MASK = 8'h0f;
  // per-link parameter set
  typedef struct packed {
    logic [7:0] lane_scr;
    logic [7:0] f_m1;
    logic [7:0] k_m1;
    logic [7:0] m_m1;
    logic [7:0] res;
    logic [7:0] pack;
    logic [7:0] ver;
    logic [7:0] dens;
    logic [7:0] f;
  } sldc_link_t;
  localparam sldc_link_t LINK_RST = '{RST_LANE_SCR, RST_ZERO, RST_K, RST_ZERO, RST_RES,
    RST_PACK, RST_VER, RST_DENS, RST_F};
  // host sequencer states, gray along the path
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_WRITE = 3'b001,
    HS_NEXT = 3'b011,
    HS_DONE = 3'b010
  } sldc_hstate_t;
endpackage : sldc_pkg

/* File: src/sldc_device.sv */
// module: deframer configuration register bank with legality checks
`timescale 1ns/1ns
module sldc_device #(
  // masks are eight bits wide, so more lanes need wider registers
  parameter int LANES = 8 // logical lane count
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  sldc_if.dev bus,
  output logic dual_link_o,
  output logic sync1_power_down_o,
  output logic scramble_en_o,
  output logic [LANES-1:0] lane_deskew_o,
  output logic [LANES-1:0] lane_active_o,
  output logic [7:0] config_error_o,
  output logic [3:0] mode_o
);
  // whole state in one struct
  typedef struct packed {
    logic [7:0] sync_pd;
    logic [7:0] link_ctrl;
    sldc_pkg::sldc_link_t link0;
    sldc_pkg::sldc_link_t link1;
    logic [7:0] deskew;
    logic [7:0] lane_en;
    logic [7:0] mfc_dly;
    logic [7:0] err;
    logic [7:0] rdata;
    logic rvalid;
  } sldc_dev_t;
  // one register for everything keeps reset and update in one place
  sldc_dev_t state_reg; // registered state
  sldc_dev_t state_next; // next state

  // mode lookup from a parameter set; 0 means no supported mode
  function automatic logic [3:0] sldc_mode(input sldc_pkg::sldc_link_t p);
    // fields of the set that pick the mode
    logic [4:0] l_m1; // lanes minus one
    logic [4:0] s_m1; // samples per frame minus one
    logic high_density_format; // samples split across lanes
    l_m1 = p.lane_scr[4:0];
    s_m1 = p.ver[4:0];
    high_density_format = p.dens[sldc_pkg::HIGH_DENSITY_BIT];
    // anything not matched below stays unsupported
    sldc_mode = 4'h0;
    // only one converter per link accepted
    if (p.m_m1 == sldc_pkg::M_ONE_M1) begin
      // both octet registers must agree
      // modes 11 to 13 are programmed as 8 to 10, so they decode here too
      if (p.f_m1 == 8'h00 && p.f == 8'h01 && high_density_format) begin
        if (l_m1 == 5'h03 && s_m1 == 5'h01) sldc_mode = 4'h8;
        else if (l_m1 == 5'h01 && s_m1 == 5'h00) sldc_mode = 4'h9;
      end else if (p.f_m1 == 8'h01 && p.f == 8'h02 && !high_density_format
                   && l_m1 == 5'h00 && s_m1 == 5'h00) begin
        sldc_mode = 4'ha;
      end
    end
  endfunction : sldc_mode

  // register writes, readback and flag evaluation
  always_comb begin
    logic wr_l1;
    logic [3:0] m0;
    logic lmfs_bad;
    logic k_bad;
    logic sub_bad;
    sldc_pkg::sldc_link_t p;
    // locals start defined so no latch is inferred
    wr_l1 = 1'b0;
    m0 = 4'h0;
    lmfs_bad = 1'b0;
    k_bad = 1'b0;
    sub_bad = 1'b0;
    p = '0;
    // hold everything unless a strobe says otherwise
    state_next = state_reg;
    // read answer pulse lasts one cycle
    state_next.rvalid = 1'b0;
    wr_l1 = state_reg.link_ctrl[sldc_pkg::LINK_PAGE_BIT];
    p = wr_l1 ? state_reg.link1 : state_reg.link0;
    if (bus.wr_en) begin
      unique case (bus.addr)
        sldc_pkg::ADDR_SYNC_PD: state_next.sync_pd = bus.wdata;
        sldc_pkg::ADDR_LINK_CTRL: state_next.link_ctrl = bus.wdata;
        // scramble bit and lanes minus one
        sldc_pkg::ADDR_LANE_SCR: p.lane_scr = bus.wdata;
        sldc_pkg::ADDR_F_M1: p.f_m1 = bus.wdata;
        sldc_pkg::ADDR_K_M1: p.k_m1 = bus.wdata;
        sldc_pkg::ADDR_M_M1: p.m_m1 = bus.wdata;
        sldc_pkg::ADDR_RES: p.res = bus.wdata;
        sldc_pkg::ADDR_PACK: p.pack = bus.wdata;
        sldc_pkg::ADDR_VER: p.ver = bus.wdata;
        sldc_pkg::ADDR_DENS: p.dens = bus.wdata;
        sldc_pkg::ADDR_F: p.f = bus.wdata;
        sldc_pkg::ADDR_DESKEW: state_next.deskew = bus.wdata;
        sldc_pkg::ADDR_LANE_EN: state_next.lane_en = bus.wdata;
        sldc_pkg::ADDR_MFC_DLY: state_next.mfc_dly = bus.wdata;
        default: ; // unmapped or read-only: ignored
      endcase
      // whole set written back; at most one field differs
      if (wr_l1) state_next.link1 = p;
      else state_next.link0 = p;
    end
    // readback shows link selected by the page bit
    if (bus.rd_en) begin
      state_next.rvalid = 1'b1;
      unique case (bus.addr)
        sldc_pkg::ADDR_CFG_ERR: state_next.rdata = state_reg.err;
        sldc_pkg::ADDR_SYNC_PD: state_next.rdata = state_reg.sync_pd;
        sldc_pkg::ADDR_LINK_CTRL: state_next.rdata = state_reg.link_ctrl;
        sldc_pkg::ADDR_LANE_SCR: state_next.rdata = p.lane_scr;
        sldc_pkg::ADDR_F_M1: state_next.rdata = p.f_m1;
        sldc_pkg::ADDR_K_M1: state_next.rdata = p.k_m1;
        sldc_pkg::ADDR_M_M1: state_next.rdata = p.m_m1;
        sldc_pkg::ADDR_RES: state_next.rdata = p.res;
        sldc_pkg::ADDR_PACK: state_next.rdata = p.pack;
        // version field read back as stored
        sldc_pkg::ADDR_VER: state_next.rdata = p.ver;
        sldc_pkg::ADDR_DENS: state_next.rdata = p.dens;
        sldc_pkg::ADDR_F: state_next.rdata = p.f;
        sldc_pkg::ADDR_DESKEW: state_next.rdata = state_reg.deskew;
        sldc_pkg::ADDR_LANE_EN: state_next.rdata = state_reg.lane_en;
        sldc_pkg::ADDR_MFC_DLY: state_next.rdata = state_reg.mfc_dly;
        // unmapped reads answer zero but still pulse
        default: state_next.rdata = 8'h00;
      endcase
    end
    // flags recomputed from present contents every cycle
    m0 = sldc_mode(state_reg.link0);
    // unsupported combination, including link mismatch in dual
    lmfs_bad = (m0 == 4'h0);
    // dual link only modes 8 to 10, which the lookup already bounds
    if (state_reg.link_ctrl[sldc_pkg::DUAL_LINK_BIT]
        && (state_reg.link1 != state_reg.link0)) lmfs_bad = 1'b1;
    // frames per multiframe: 32, or 16 only with two octets
    k_bad = !(state_reg.link0.k_m1[4:0] == sldc_pkg::K32_M1
              || (state_reg.link0.k_m1[4:0] == sldc_pkg::K16_M1 && m0 == 4'ha))
            || (state_reg.link0.k_m1[7:5] != 3'h0);
    sub_bad = !(state_reg.link0.pack[7:5] == sldc_pkg::SUBCLASS_0
                || state_reg.link0.pack[7:5] == sldc_pkg::SUBCLASS_1);
    // flags rebuilt every cycle, so none needs a clear
    state_next.err = 8'h00;
    // delay must fit within one multiframe
    state_next.err[sldc_pkg::ERR_MFC_DLY_BIT] =
      (state_reg.mfc_dly > {3'h0, state_reg.link0.k_m1[4:0]});
    state_next.err[sldc_pkg::ERR_LMFS_BIT] = lmfs_bad;
    state_next.err[sldc_pkg::ERR_K_BIT] = k_bad;
    state_next.err[sldc_pkg::ERR_SUBCLASS_BIT] = sub_bad;
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // single link, mode 8 parameters, four lanes deskewed and enabled
      state_reg <= '{sldc_pkg::RST_ZERO, sldc_pkg::RST_ZERO, sldc_pkg::LINK_RST,
        sldc_pkg::LINK_RST, sldc_pkg::RST_MASK, sldc_pkg::RST_MASK, sldc_pkg::RST_ZERO,
        sldc_pkg::RST_ZERO, sldc_pkg::RST_ZERO, 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // dual link select drives the link mux
  assign dual_link_o = state_reg.link_ctrl[sldc_pkg::DUAL_LINK_BIT];
  // buffer power down for the second sync output
  assign sync1_power_down_o = state_reg.sync_pd[sldc_pkg::SYNC1_PD_BIT];
  // descrambler follows link0; link1 must match it anyway
  assign scramble_en_o = state_reg.link0.lane_scr[sldc_pkg::SCRAMBLE_BIT];
  // deskew mask straight from its register
  assign lane_deskew_o = state_reg.deskew[LANES-1:0];
  // only deskewed and enabled lanes feed the converters
  assign lane_active_o = state_reg.lane_en[LANES-1:0] & state_reg.deskew[LANES-1:0];
  // flags come from the register, one cycle behind the contents
  assign config_error_o = state_reg.err;
  // mode decoded live: a lookup traded for a saved register
  assign mode_o = sldc_mode(state_reg.link0);
  // read data stands until the next read
  assign bus.rdata = state_reg.rdata;
  assign bus.rvalid = state_reg.rvalid;
endmodule : sldc_device

/* File: src/sldc_host.sv */
// module: host sequencer programming one mode into the deframer registers
`timescale 1ns/1ns
module sldc_host (
  input wire logic clk_i,
  input wire logic reset_n_i,
  sldc_if.host bus,
  input wire logic start_i, // one-cycle pulse
  input wire logic [3:0] mode_i, // 8 to 13
  input wire logic dual_i, // dual link request
  input wire logic scramble_i,
  input wire logic subclass1_i,
  input wire logic k16_i, // 16 frames, modes 10 and 13
  output logic busy_o,
  output logic done_o // one-cycle pulse
);
  typedef struct packed {
    sldc_pkg::sldc_hstate_t st;
    logic [4:0] idx;
    logic page;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic done;
  } sldc_host_t;
  sldc_host_t s_reg; // registered state
  sldc_host_t s_next; // next state
  localparam logic [4:0] LAST_IDX = 5'd13;

  // step table; modes 11-13 program as 8-10 with doubled lane masks
  function automatic logic [19:0] sldc_step(input logic [4:0] i, input logic [3:0] m,
                                            input logic sc, input logic s1, input logic k16,
                                            input logic pg);
    logic [1:0] md;
    logic [7:0] mask;
    md = (m >= 4'hb) ? 2'(m - 4'hb) : 2'(m - 4'h8);
    mask = (m == 4'hb) ? 8'hff : (m == 4'hc) ? 8'h33 : (m == 4'hd) ? 8'h11 :
           (md == 2'd0) ? 8'h0f : (md == 2'd1) ? 8'h03 : 8'h01;
    unique case (i)
      5'd0: sldc_step = {sldc_pkg::ADDR_LINK_CTRL, 4'h0, dual_i, pg, 2'b00};
      // mode 11 written as four lanes
      5'd1: sldc_step = {sldc_pkg::ADDR_LANE_SCR, sc, 2'b00,
                         (md == 2'd0) ? 5'h03 : (md == 2'd1) ? 5'h01 : 5'h00};
      5'd2: sldc_step = {sldc_pkg::ADDR_F_M1, (md == 2'd2) ? 8'h01 : 8'h00};
      5'd3: sldc_step = {sldc_pkg::ADDR_K_M1, 3'h0,
                         (md == 2'd2 && k16) ? sldc_pkg::K16_M1 : sldc_pkg::K32_M1};
      5'd4: sldc_step = {sldc_pkg::ADDR_M_M1, sldc_pkg::M_ONE_M1};
      5'd5: sldc_step = {sldc_pkg::ADDR_RES, 3'h0, sldc_pkg::RES16_M1};
      5'd6: sldc_step = {sldc_pkg::ADDR_PACK, s1 ? sldc_pkg::SUBCLASS_1 : sldc_pkg::SUBCLASS_0,
                         sldc_pkg::RES16_M1};
      5'd7: sldc_step = {sldc_pkg::ADDR_VER, sldc_pkg::VERSION_B,
                         (md == 2'd0) ? 5'h01 : 5'h00};
      5'd8: sldc_step = {sldc_pkg::ADDR_DENS, (md != 2'd2), 7'h00};
      5'd9: sldc_step = {sldc_pkg::ADDR_F, (md == 2'd2) ? 8'h02 : 8'h01};
      5'd10: sldc_step = {sldc_pkg::ADDR_SYNC_PD, 7'h00, !dual_i};
      5'd11: sldc_step = {sldc_pkg::ADDR_DESKEW, mask};
      5'd12: sldc_step = {sldc_pkg::ADDR_LANE_EN, mask};
      default: sldc_step = {sldc_pkg::ADDR_LINK_CTRL, 4'h0, dual_i, 3'b000};
    endcase
  endfunction : sldc_step

  // sequencer
  always_comb begin
    logic [19:0] step;
    step = sldc_step(s_reg.idx, mode_i, scramble_i, subclass1_i, k16_i, s_reg.page);
    s_next = s_reg;
    s_next.wr = 1'b0;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      sldc_pkg::HS_IDLE: begin
        // dual link only accepted for modes 8 to 10
        if (start_i && mode_i >= 4'h8 && mode_i <= 4'hd && !(dual_i && mode_i > 4'ha)) begin
          s_next.st = sldc_pkg::HS_WRITE;
          s_next.idx = 5'd0;
          s_next.page = 1'b0;
        end
      end
      sldc_pkg::HS_WRITE: begin
        s_next.wr = 1'b1;
        s_next.addr = step[19:8];
        s_next.wdata = step[7:0];
        s_next.st = sldc_pkg::HS_NEXT;
      end
      sldc_pkg::HS_NEXT: begin
        s_next.st = sldc_pkg::HS_WRITE;
        s_next.idx = 5'(s_reg.idx + 5'd1);
        // second pass writes identical set to link1
        if (s_reg.idx == 5'd9 && dual_i && !s_reg.page) begin
          s_next.page = 1'b1;
          s_next.idx = 5'd0;
        end else if (s_reg.idx == LAST_IDX) begin
          s_next.st = sldc_pkg::HS_DONE;
        end
      end
      sldc_pkg::HS_DONE: begin
        s_next.done = 1'b1;
        s_next.st = sldc_pkg::HS_IDLE;
      end
      default: s_next.st = sldc_pkg::HS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '{sldc_pkg::HS_IDLE, 5'd0, 1'b0, 1'b0, 12'h000, 8'h00, 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.wr_en = s_reg.wr;
  assign bus.rd_en = 1'b0;
  assign bus.addr = s_reg.addr;
  assign bus.wdata = s_reg.wdata;
  assign busy_o = (s_reg.st != sldc_pkg::HS_IDLE);
  assign done_o = s_reg.done;
endmodule : sldc_host

/* File: tb/serial_link_deframer_config_tb_top.sv */
// testbench: host against device, plus a second device driven directly
`timescale 1ns/1ns
module serial_link_deframer_config_tb_top;
  logic clk_i;
  logic reset_n_i;
  logic h_start, h_dual, h_scr, h_s1, h_k16, h_busy, h_done; // host user side
  logic [3:0] h_mode;
  logic a_dual, a_sync, a_scr, b_dual, b_sync; // device outputs
  logic [7:0] a_desk, a_act, a_err, b_desk, b_act;
  logic [3:0] a_mode;
  logic [7:0] v;
  int err_total;
  int comparisons;
  logic [7:0] rd_q[$]; // expected read data
  logic [30:0] cfg_q[$]; // expected device outputs after a host run
  localparam logic [11:0] RA [0:14] = '{12'h453, 12'h454, 12'h455, 12'h456, 12'h457,
    12'h458, 12'h459, 12'h45a, 12'h476, 12'h46c, 12'h47d, 12'h300, 12'h203, 12'h030, 12'h7ff};
  localparam logic [7:0] RV [0:14] = '{8'h03, 8'h00, 8'h1f, 8'h00, 8'h0f, 8'h0f, 8'h21,
    8'h80, 8'h01, 8'h0f, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MASK [0:5] = '{8'h0f, 8'h03, 8'h01, 8'hff, 8'h33, 8'h11};
  sldc_if link_if ();
  sldc_if probe_if ();
  sldc_host sldc_host_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(link_if),
    .start_i(h_start), .mode_i(h_mode), .dual_i(h_dual), .scramble_i(h_scr),
    .subclass1_i(h_s1), .k16_i(h_k16), .busy_o(h_busy), .done_o(h_done));
  sldc_device sldc_device_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(link_if),
    .dual_link_o(a_dual), .sync1_power_down_o(a_sync), .scramble_en_o(a_scr),
    .lane_deskew_o(a_desk), .lane_active_o(a_act), .config_error_o(a_err), .mode_o(a_mode));
  // second device: lets the bench reach reads, flags and refusals
  sldc_device sldc_device_b_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(probe_if),
    .dual_link_o(b_dual), .sync1_power_down_o(b_sync), .scramble_en_o(),
    .lane_deskew_o(b_desk), .lane_active_o(b_act), .config_error_o(), .mode_o());
  sldc_properties sldc_properties_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .wr_en(link_if.wr_en), .rd_en(link_if.rd_en), .addr(link_if.addr),
    .wdata(link_if.wdata), .rdata(link_if.rdata), .rvalid(link_if.rvalid));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic final_report;
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic check(input logic [30:0] got, input logic [30:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // strobe held one edge; caller lowers with idle, so no double assignment
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    probe_if.wr_en = w;
    probe_if.rd_en = !w;
    probe_if.addr = a;
    probe_if.wdata = d;
    @(posedge clk_i);
    #5;
  endtask : xfer
  task automatic idle;
    probe_if.wr_en = 1'b0;
    probe_if.rd_en = 1'b0;
    @(posedge clk_i);
    #5;
  endtask : idle
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    xfer(1'b0, a, 8'h00);
  endtask : rd
  // flags settle one cycle after the write, hence the idle
  task automatic wr_chk(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
    xfer(1'b1, a, d);
    idle;
    rd(12'h030, e);
  endtask : wr_chk
  task automatic run_mode(input logic [3:0] m, input logic dl, input logic ok);
    int i;
    h_mode = m;
    h_dual = dl;
    h_scr = 1'($urandom);
    h_s1 = 1'($urandom);
    h_k16 = (m == 4'd10 || m == 4'd13) ? 1'($urandom) : 1'b0;
    // modes above 10 share the receive settings of the mode three below
    if (ok) cfg_q.push_back({dl, !dl, h_scr, MASK[m-8], MASK[m-8], 8'h00,
      (m > 10) ? m - 4'd3 : m});
    h_start = 1'b1;
    @(posedge clk_i);
    #5;
    h_start = 1'b0;
    if (!ok) begin
      @(negedge clk_i);
      check({30'h0, h_busy}, 31'h0, "start refused");
    end else begin
      for (i = 0; i < 100 && h_done !== 1'b1; i++) @(negedge clk_i);
      if (i == 100) check(31'h0, 31'h1, "no done");
    end
    @(posedge clk_i);
    #5;
  endtask : run_mode
  // read answers, compared oldest first
  always @(negedge clk_i) begin
    if (probe_if.rvalid === 1'b1) begin
      check({23'h0, probe_if.rdata}, {23'h0, rd_q.pop_front()}, "rd");
    end
    if (h_done === 1'b1) begin
      check({a_dual, a_sync, a_scr, a_desk, a_act, a_err, a_mode},
        cfg_q.pop_front(), "config");
    end
  end
  // watchdog: all tests take well under a thousand cycles
  initial begin
    #(4000 * 100);
    err_total++;
    final_report;
  end
  initial begin
    err_total = 0;
    comparisons = 0;
    reset_n_i = 1'b0;
    {h_start, h_dual, h_scr, h_s1, h_k16} = 5'h00;
    h_mode = 4'h8;
    {probe_if.wr_en, probe_if.rd_en, probe_if.addr, probe_if.wdata} = 22'h0;
    void'($urandom(62587));
    repeat (3) @(posedge clk_i);
    #5;
    reset_n_i = 1'b1;
    foreach (RA[i]) rd(RA[i], RV[i]);
    xfer(1'b1, 12'h300, 8'h0c);
    xfer(1'b1, 12'h453, 8'h83);
    idle;
    rd(12'h453, 8'h83);
    rd(12'h030, 8'h08);
    xfer(1'b1, 12'h453, 8'h03);
    xfer(1'b1, 12'h300, 8'h08);
    idle;
    rd(12'h453, 8'h03);
    rd(12'h030, 8'h00);
    idle;
    check({30'h0, b_dual}, 31'h1, "dual");
    xfer(1'b1, 12'h300, 8'h00);
    wr_chk(12'h455, 8'h10, 8'h04);
    wr_chk(12'h455, 8'h1f, 8'h00);
    wr_chk(12'h458, 8'h4f, 8'h02);
    wr_chk(12'h458, 8'h2f, 8'h00);
    v = 8'($urandom_range(63));
    wr_chk(12'h4f0, v, (v > 8'h1f) ? 8'h20 : 8'h00);
    wr_chk(12'h4f0, 8'h20, 8'h20);
    wr_chk(12'h030, 8'hff, 8'h20);
    wr_chk(12'h4f0, 8'h1f, 8'h00);
    v = 8'($urandom);
    xfer(1'b1, 12'h203, 8'h01);
    xfer(1'b1, 12'h46c, 8'h0f);
    xfer(1'b1, 12'h47d, v);
    idle;
    check({30'h0, b_sync}, 31'h1, "sync down");
    check({23'h0, b_desk}, 31'h0f, "deskew");
    check({23'h0, b_act}, {23'h0, v & 8'h0f}, "active");
    for (int m = 8; m <= 13; m++) run_mode(4'(m), 1'b0, 1'b1);
    for (int m = 8; m <= 10; m++) run_mode(4'(m), 1'b1, 1'b1);
    run_mode(4'd11, 1'b1, 1'b0);
    run_mode(4'd14, 1'b0, 1'b0);
    final_report;
  end
endmodule : serial_link_deframer_config_tb_top

/* File: tb/sldc_properties.sv */
// checker: order and field values of host writes on the register port
`timescale 1ns/1ns
module sldc_properties (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // host spaces writes by one idle cycle
  a_write_spacing: assert property (wr_en |=> !wr_en)
    else $error("host write strobes back to back");
  a_opens_ctrl: assert property (!wr_en [*4] ##1 wr_en |-> addr == 12'h300)
    else $error("sequence does not open on link control");
  // each parameter pass follows a link control write that sets the page
  a_page_first: assert property (wr_en && addr == 12'h453 |-> $past(addr, 2) == 12'h300)
    else $error("lane register not preceded by link control");
  a_lane_field: assert property (wr_en && addr == 12'h453 |-> wdata[6:5] == 2'h0
    && wdata[4:0] inside {5'h03, 5'h01, 5'h00}) else $error("lane count field wrong");
  // plain octet count is one above the minus-one copy seven writes back
  a_octet_pair: assert property (wr_en && addr == 12'h476 |->
    $past(addr, 14) == 12'h454 && wdata == $past(wdata, 14) + 8'h01)
    else $error("octet registers disagree");
  a_k_field: assert property (wr_en && addr == 12'h455 |-> wdata inside {8'h1f, 8'h0f})
    else $error("frames per multiframe field wrong");
  a_density_field: assert property (wr_en && addr == 12'h45a |->
    wdata[4:0] == 5'h00 && wdata[7] == ($past(wdata, 12) == 8'h00))
    else $error("density register wrong");
  // capture only enabled after deskew was written
  a_enable_after: assert property (wr_en && addr == 12'h47d |->
    $past(wr_en, 2) && $past(addr, 2) == 12'h46c) else $error("enable before deskew");
  c_page_one: cover property (wr_en && addr == 12'h300 && wdata[2]);
  c_short_k: cover property (wr_en && addr == 12'h455 && wdata == 8'h0f);
  c_enable: cover property (wr_en && addr == 12'h47d);
endmodule : sldc_properties
